// >>> hdl/relocation_pkg.sv
package relocation_pkg;
	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [11:0] OFS_CTRL    = 12'h000;
	localparam logic [11:0] OFS_CONFIG  = 12'h004;
	localparam logic [11:0] OFS_FAULTVA = 12'h008;
	localparam logic [11:0] OFS_RESTART = 12'h00c;
	localparam logic [11:0] OFS_BASE    = 12'h100;
	localparam logic [11:0] OFS_DESC    = 12'h200;
	localparam int          NUM_PAGES   = 48;

	// ---------------------------------------------------------------
	// control/status register fields
	// ---------------------------------------------------------------
	localparam int CTRL_ENABLE   = 0;
	localparam int CTRL_PAGE_LO  = 1;
	localparam int CTRL_DSPACE   = 4;
	localparam int CTRL_MODE_LO  = 5;
	localparam int CTRL_TRAP_EN  = 9;
	localparam int CTRL_TRAP     = 12;
	localparam int CTRL_ABT_RO   = 13;
	localparam int CTRL_ABT_LEN  = 14;
	localparam int CTRL_ABT_NR   = 15;
	localparam logic [15:0] CTRL_SW_MASK  = 16'hf201;
	localparam logic [15:0] CTRL_RESET    = 16'h0000;
	localparam logic [15:0] CONFIG_RESET  = 16'h0000;
	localparam int CFG_EXTENDED  = 4;

	// ---------------------------------------------------------------
	// virtual address and descriptor fields
	// ---------------------------------------------------------------
	localparam int VA_PAGE_LO   = 13;
	localparam int VA_BLOCK_LO  = 6;
	localparam int DESC_LEN_LO  = 8;
	localparam int DESC_ACC     = 7;
	localparam int DESC_WR      = 6;
	localparam int DESC_DIR     = 3;
	localparam logic [15:0] DESC_RESET = 16'h0000;
	localparam logic [15:0] BASE_RESET = 16'h0000;
	localparam logic [3:0]  PERIPH_TOP = 4'hf;

	// abort and trap vector, 250 octal
	localparam logic [15:0] MM_VECTOR = 16'h00a8;

	// ---------------------------------------------------------------
	// enumerations
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_KERNEL  = 2'h0,
		MODE_SUPER   = 2'h1,
		MODE_ILLEGAL = 2'h2,
		MODE_USER    = 2'h3
	} cpu_mode_t;

	typedef enum logic [1:0] {
		MAP_16,
		MAP_18,
		MAP_22
	} map_mode_t;

	typedef enum logic [2:0] {
		KEY_NR0      = 3'h0,
		KEY_RO_TRAP  = 3'h1,
		KEY_RO       = 3'h2,
		KEY_NR3      = 3'h3,
		KEY_RW_TRAP  = 3'h4,
		KEY_RW_TRAPW = 3'h5,
		KEY_RW       = 3'h6,
		KEY_NR7      = 3'h7
	} access_key_t;
endpackage

// >>> hdl/relocation_adder.sv
`timescale 1ns/10ps
module relocation_adder (
	input  wire logic [15:0]                  pageBase,
	input  wire logic [15:0]                  virtAddr,
	input  wire relocation_pkg::map_mode_t    mapMode,
	output logic      [21:0]                  physAddr,
	output logic                              toPeriph
);
	logic [15:0] blockSum;
	logic [17:0] addr18;

	// ---------------------------------------------------------------
	// block add and mapping width
	// ---------------------------------------------------------------
	// sum spans the whole base so 22-bit results are reachable
	assign blockSum = pageBase + {9'h000, virtAddr[12:relocation_pkg::VA_BLOCK_LO]};
	// low six bits pass straight through
	assign addr18 = {blockSum[11:0], virtAddr[5:0]};

	// top page of 16/18-bit space folds onto the peripheral page
	always_comb begin
		unique case (mapMode)
			relocation_pkg::MAP_16: begin
				physAddr = (virtAddr[15:13] == 3'h7) ?
					{6'h3f, virtAddr} : {6'h00, virtAddr};
			end
			relocation_pkg::MAP_18: begin
				physAddr = (addr18[17:13] == 5'h1f) ?
					{4'hf, addr18} : {4'h0, addr18};
			end
			default: begin
				physAddr = {blockSum, virtAddr[5:0]};
			end
		endcase
	end

	assign toPeriph = (physAddr[21:18] == relocation_pkg::PERIPH_TOP);
endmodule

// >>> hdl/access_checker.sv
`timescale 1ns/10ps
module access_checker (
	input  wire logic [15:0] descriptor,
	input  wire logic [6:0]  blockNum,
	input  wire logic        isWrite,
	input  wire logic        modeLegal,
	output logic             abortNonRes,
	output logic             abortLength,
	output logic             abortReadOnly,
	output logic             trapHit
);
	logic [6:0] pageLen;
	logic       downward;
	relocation_pkg::access_key_t key;

	// ---------------------------------------------------------------
	// length and key checks
	// ---------------------------------------------------------------
	assign pageLen  = descriptor[relocation_pkg::DESC_LEN_LO +: 7];
	assign downward = descriptor[relocation_pkg::DESC_DIR];
	assign key      = relocation_pkg::access_key_t'(descriptor[2:0]);

	// upward pages end at the length, downward pages start at it
	assign abortLength = modeLegal &&
		(downward ? (blockNum < pageLen) : (blockNum > pageLen));

	// illegal mode is reported as non-resident
	always_comb begin
		abortNonRes   = !modeLegal;
		abortReadOnly = 1'b0;
		trapHit       = 1'b0;
		unique case (key)
			relocation_pkg::KEY_RO_TRAP: begin
				abortReadOnly = isWrite;
				trapHit       = !isWrite;
			end
			relocation_pkg::KEY_RO: begin
				abortReadOnly = isWrite;
			end
			relocation_pkg::KEY_RW_TRAP: begin
				trapHit = 1'b1;
			end
			relocation_pkg::KEY_RW_TRAPW: begin
				trapHit = isWrite;
			end
			relocation_pkg::KEY_RW: begin
				trapHit = 1'b0;
			end
			default: begin
				abortNonRes = 1'b1;
			end
		endcase
	end
endmodule

// >>> hdl/paged_address_relocation_protection.sv
`timescale 1ns/10ps
// Behaviour
// - virtual address bits 15:13 pick one of eight page pairs.
// - separate page sets for kernel, supervisor and user modes.
// - instruction-stream references use instruction group, others the data group.
// - page base is a physical block number of 32 words.
// - add virtual block number bits 12:6 to the page base.
// - low six virtual bits pass unchanged as displacement in block.
// - page length field 14:8 limits page, up to 128 blocks.
// - descriptor bit 3 selects upward or downward expansion.
// - non-resident blocks all access; read-only blocks writes.
// - accessed bit set on any non-aborted reference with relocation on, written bit on writes.
// - violation aborts the cycle at once, before instruction ends.
// - trap held until instruction completes, then raised.
// - aborts and traps vector to 250 octal.
// - abort records page, violation type and restart state.
// - three key codes request a trap instead of abort.
// - address goes to cache or peripheral bus; faults reported back.
// - each page relocated independently; shared bases allowed.
// - physical bits 21:18 all ones go to peripheral bus.
// - 16, 18 or 22-bit mapping from enable and extended bits.
// - per-mode config bits enable data-space group.
// - page base is sixteen bits, times 64 bytes.
module paged_address_relocation_protection (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        cpuReq,
	input  wire logic [15:0] cpuVa,
	input  wire logic [1:0]  cpuMode,
	input  wire logic        cpuIspace,
	input  wire logic        cpuWrite,
	input  wire logic [15:0] cpuRestart,
	input  wire logic        cpuInstrDone,
	output logic      [21:0] physAddr,
	output logic             cacheStrobe,
	output logic             periphStrobe,
	output logic             abortReq,
	output logic             trapReq,
	output logic      [15:0] vectorAddr
);
	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	logic [15:0] pageBase_reg [0:relocation_pkg::NUM_PAGES-1];
	logic [15:0] pageDesc_reg [0:relocation_pkg::NUM_PAGES-1];
	logic [15:0] ctrl_reg;
	logic [15:0] config_reg;
	logic [15:0] faultVa_reg;
	logic [15:0] restart_reg;
	logic        trapPending_reg;

	// bus pipeline
	logic        wrPend_reg;
	logic [11:0] wrAddr_reg;
	logic        addrPhase;
	logic        rdAccept;
	logic [31:0] rdValue;

	// translation path
	logic [1:0]  modeIdx;
	logic        modeLegal;
	logic        useDspace;
	logic [5:0]  pageIdx;
	logic [15:0] selBase;
	logic [15:0] selDesc;
	relocation_pkg::map_mode_t mapMode;
	logic [21:0] relocAddr;
	logic        relocPeriph;
	logic        abtNr;
	logic        abtLen;
	logic        abtRo;
	logic        trapHit;
	logic        anyAbort;
	logic        goodRef;
	logic        freeze;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// mode code to set number, user takes the third set
	function automatic logic [1:0] modeToSet(input logic [1:0] m);
		modeToSet = (m == 2'h3) ? 2'h2 : m;
	endfunction

	// set, space and page number to flat page index, used by the cpu decode only
	function automatic logic [5:0] flatIndex(input logic [1:0] setNum,
			input logic dsp, input logic [2:0] page);
		flatIndex = {setNum, dsp, page};
	endfunction

	// bus offset lies inside one of the page arrays
	function automatic logic inArray(input logic [11:0] ofs,
			input logic [11:0] base);
		inArray = (ofs[11:8] == base[11:8]) && (ofs[7:2] < 6'd48);
	endfunction

	// ---------------------------------------------------------------
	// page selection
	// ---------------------------------------------------------------
	assign modeIdx   = modeToSet(cpuMode);
	assign modeLegal = (cpuMode != relocation_pkg::MODE_ILLEGAL);
	// data group only when the running mode has it switched on
	assign useDspace = !cpuIspace && config_reg[modeIdx];
	assign pageIdx   = flatIndex(modeIdx, useDspace,
		cpuVa[15:relocation_pkg::VA_PAGE_LO]);
	// each pair is read alone, so shared bases need nothing special
	assign selBase   = pageBase_reg[pageIdx];
	assign selDesc   = pageDesc_reg[pageIdx];

	// mapping width from enable and extended bits
	always_comb begin
		if (!ctrl_reg[relocation_pkg::CTRL_ENABLE]) begin
			mapMode = relocation_pkg::MAP_16;
		end else if (config_reg[relocation_pkg::CFG_EXTENDED]) begin
			mapMode = relocation_pkg::MAP_22;
		end else begin
			mapMode = relocation_pkg::MAP_18;
		end
	end

	relocation_adder adder (
		.pageBase (selBase),
		.virtAddr (cpuVa),
		.mapMode  (mapMode),
		.physAddr (relocAddr),
		.toPeriph (relocPeriph)
	);

	access_checker accessCheck (
		.descriptor    (selDesc),
		.blockNum      (cpuVa[12:relocation_pkg::VA_BLOCK_LO]),
		.isWrite       (cpuWrite),
		.modeLegal     (modeLegal),
		.abortNonRes   (abtNr),
		.abortLength   (abtLen),
		.abortReadOnly (abtRo),
		.trapHit       (trapHit)
	);

	// checks apply only with relocation on
	assign anyAbort = cpuReq && ctrl_reg[relocation_pkg::CTRL_ENABLE] &&
		(abtNr || abtLen || abtRo);
	assign goodRef  = cpuReq && !anyAbort;
	// first fault's record is kept until software clears the flags
	assign freeze   = |ctrl_reg[15:13];

	// ---------------------------------------------------------------
	// processor side outputs
	// ---------------------------------------------------------------
	// address registered, strobe names its destination
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			physAddr     <= 22'h000000;
			cacheStrobe  <= 1'b0;
			periphStrobe <= 1'b0;
		end else begin
			if (goodRef) begin
				physAddr <= relocAddr;
			end
			cacheStrobe  <= goodRef && !relocPeriph;
			periphStrobe <= goodRef && relocPeriph;
		end
	end

	// abort goes out next cycle, without waiting for instruction end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			abortReq <= 1'b0;
		end else begin
			abortReq <= anyAbort;
		end
	end

	// trap waits for the instruction to finish
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			trapPending_reg <= 1'b0;
			trapReq         <= 1'b0;
		end else begin
			trapReq <= cpuInstrDone && trapPending_reg;
			if (goodRef && trapHit && ctrl_reg[relocation_pkg::CTRL_TRAP_EN] &&
					ctrl_reg[relocation_pkg::CTRL_ENABLE]) begin
				trapPending_reg <= 1'b1;
			end else if (cpuInstrDone || anyAbort) begin
				trapPending_reg <= 1'b0;
			end
		end
	end

	// one vector serves both events
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			vectorAddr <= 16'h0000;
		end else if (anyAbort || (cpuInstrDone && trapPending_reg)) begin
			vectorAddr <= relocation_pkg::MM_VECTOR;
		end
	end

	// ---------------------------------------------------------------
	// bus slave, zero wait except read after write
	// ---------------------------------------------------------------
	assign addrPhase = hsel && htrans[1] && hready;
	// stall a read behind a pending write so it sees fresh data
	assign hreadyout = !(wrPend_reg && hsel && htrans[1] && !hwrite);
	assign hresp     = 1'b0;
	assign rdAccept  = addrPhase && !hwrite;

	// write address captured in address phase, data used next cycle
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			wrPend_reg <= 1'b0;
			wrAddr_reg <= 12'h000;
		end else begin
			wrPend_reg <= addrPhase && hwrite && (hsize == 3'h2);
			if (addrPhase) begin
				wrAddr_reg <= haddr[11:0];
			end
		end
	end

	// read mux, unmapped offsets read zero
	always_comb begin
		rdValue = 32'h00000000;
		if (inArray(haddr[11:0], relocation_pkg::OFS_BASE)) begin
			rdValue = {16'h0000, pageBase_reg[haddr[7:2]]};
		end else if (inArray(haddr[11:0], relocation_pkg::OFS_DESC)) begin
			rdValue = {16'h0000, pageDesc_reg[haddr[7:2]]};
		end else begin
			unique case (haddr[11:0])
				relocation_pkg::OFS_CTRL:    rdValue = {16'h0000, ctrl_reg};
				relocation_pkg::OFS_CONFIG:  rdValue = {16'h0000, config_reg};
				relocation_pkg::OFS_FAULTVA: rdValue = {16'h0000, faultVa_reg};
				relocation_pkg::OFS_RESTART: rdValue = {16'h0000, restart_reg};
				default:                     rdValue = 32'h00000000;
			endcase
		end
	end

	// read data lands at the start of the data phase
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			hrdata <= 32'h00000000;
		end else if (rdAccept) begin
			hrdata <= rdValue;
		end
	end

	// ---------------------------------------------------------------
	// page arrays
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			for (int i = 0; i < relocation_pkg::NUM_PAGES; i++) begin
				pageBase_reg[i] <= relocation_pkg::BASE_RESET;
			end
		end else if (wrPend_reg && inArray(wrAddr_reg, relocation_pkg::OFS_BASE)) begin
			pageBase_reg[wrAddr_reg[7:2]] <= hwdata[15:0];
		end
	end

	// status bits set by hardware win over a same-cycle bus write
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			for (int i = 0; i < relocation_pkg::NUM_PAGES; i++) begin
				pageDesc_reg[i] <= relocation_pkg::DESC_RESET;
			end
		end else begin
			if (wrPend_reg && inArray(wrAddr_reg, relocation_pkg::OFS_DESC)) begin
				pageDesc_reg[wrAddr_reg[7:2]] <= hwdata[15:0];
			end
			if (goodRef && ctrl_reg[relocation_pkg::CTRL_ENABLE]) begin
				pageDesc_reg[pageIdx][relocation_pkg::DESC_ACC] <= 1'b1;
				if (cpuWrite) begin
					pageDesc_reg[pageIdx][relocation_pkg::DESC_WR] <= 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// control, config and fault record
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			config_reg <= relocation_pkg::CONFIG_RESET;
		end else if (wrPend_reg && wrAddr_reg == relocation_pkg::OFS_CONFIG) begin
			config_reg <= {11'h000, hwdata[4], 1'b0, hwdata[2:0]};
		end
	end

	// abort flags and page latch freeze on the first fault
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl_reg <= relocation_pkg::CTRL_RESET;
		end else begin
			if (wrPend_reg && wrAddr_reg == relocation_pkg::OFS_CTRL) begin
				ctrl_reg <= (ctrl_reg & ~relocation_pkg::CTRL_SW_MASK) |
					(hwdata[15:0] & relocation_pkg::CTRL_SW_MASK);
			end
			if (anyAbort && !freeze) begin
				ctrl_reg[relocation_pkg::CTRL_ABT_NR]  <= abtNr;
				ctrl_reg[relocation_pkg::CTRL_ABT_LEN] <= abtLen;
				ctrl_reg[relocation_pkg::CTRL_ABT_RO]  <= abtRo;
				ctrl_reg[relocation_pkg::CTRL_MODE_LO +: 2] <= cpuMode;
				ctrl_reg[relocation_pkg::CTRL_DSPACE]  <= useDspace;
				ctrl_reg[relocation_pkg::CTRL_PAGE_LO +: 3] <= cpuVa[15:13];
			end
			if (cpuInstrDone && trapPending_reg) begin
				ctrl_reg[relocation_pkg::CTRL_TRAP] <= 1'b1;
			end
		end
	end

	// restart state for the aborted instruction
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			faultVa_reg <= 16'h0000;
			restart_reg <= 16'h0000;
		end else if (anyAbort && !freeze) begin
			faultVa_reg <= cpuVa;
			restart_reg <= cpuRestart;
		end
	end
endmodule

// >>> dv/relocation_checker.sv
`timescale 1ns/10ps
module relocation_checker (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        cpuReq,
	input  wire logic [15:0] cpuVa,
	input  wire logic        cpuInstrDone,
	input  wire logic [21:0] physAddr,
	input  wire logic        cacheStrobe,
	input  wire logic        periphStrobe,
	input  wire logic        abortReq,
	input  wire logic        trapReq,
	input  wire logic [15:0] vectorAddr
);
	logic [15:0] lastVa;

	// one clock domain, so clocking and reset are given once
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// previous request address, avoids slicing a sampled value
	always_ff @(posedge sys_clk) begin
		lastVa <= cpuVa;
	end

	// request answered towards memory or the bus
	sequence goodAnswer;
		cpuReq ##1 (cacheStrobe || periphStrobe);
	endsequence

	// request answered by an abort
	sequence abortAnswer;
		cpuReq ##1 abortReq;
	endsequence

	chk_abort_vector: assert property (abortReq |-> vectorAddr == 16'h00a8)
		else $error("abort without fixed vector");
	chk_trap_vector: assert property (trapReq |-> vectorAddr == 16'h00a8)
		else $error("trap without fixed vector");
	chk_one_answer: assert property (
		cpuReq |=> $onehot({cacheStrobe, periphStrobe, abortReq}))
		else $error("request not answered exactly once");
	chk_no_spurious: assert property (
		!cpuReq |=> !(cacheStrobe || periphStrobe || abortReq))
		else $error("answer without request");
	chk_route_split: assert property (
		(cacheStrobe || periphStrobe) |-> (periphStrobe == (physAddr[21:18] == 4'hf)))
		else $error("address sent to wrong target");
	chk_disp_pass: assert property (goodAnswer |-> physAddr[5:0] == lastVa[5:0])
		else $error("displacement in block altered");
	chk_abort_hold: assert property (abortAnswer |-> $stable(physAddr))
		else $error("aborted cycle changed the address");
	chk_trap_after_done: assert property (trapReq |-> $past(cpuInstrDone))
		else $error("trap before instruction end");
endmodule

bind paged_address_relocation_protection relocation_checker chk (
	.sys_clk(sys_clk), .nrst(nrst), .cpuReq(cpuReq), .cpuVa(cpuVa),
	.cpuInstrDone(cpuInstrDone), .physAddr(physAddr), .cacheStrobe(cacheStrobe),
	.periphStrobe(periphStrobe), .abortReq(abortReq), .trapReq(trapReq),
	.vectorAddr(vectorAddr)
);

// >>> dv/memory_side_model.sv
`timescale 1ns/10ps
module memory_side_model (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic [21:0] physAddr,
	input  wire logic        cacheStrobe,
	input  wire logic        periphStrobe,
	output int               cacheHits,
	output int               periphHits
);
	// cache and peripheral bus only count what reaches them; a cycle
	// that arrives at both would be seen as two hits and show up
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cacheHits <= 0;
			periphHits <= 0;
		end else begin
			if (cacheStrobe) cacheHits <= cacheHits + 1;
			if (periphStrobe && physAddr[21:18] == 4'hf) periphHits <= periphHits + 1;
		end
	end
endmodule

// >>> dv/tb_paged_address_relocation_protection.sv
`timescale 1ns/10ps
module tb_paged_address_relocation_protection;
	logic        sys_clk, nrst, hsel, hwrite, hreadyout, hresp;
	logic        cpuReq, cpuIspace, cpuWrite, cpuInstrDone;
	logic        cacheStrobe, periphStrobe, abortReq, trapReq;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans, cpuMode;
	logic [2:0]  hsize;
	logic [15:0] cpuVa, cpuRestart, vectorAddr, va;
	logic [21:0] physAddr;
	logic [15:0] bases [3] = '{16'hffc0, 16'hefc0, 16'h00fb};
	int          kinds [3] = '{1, 0, 0};
	int          fails, num_checks, expC, expP, cacheHits, periphHits;
	logic        ab, tr;

	paged_address_relocation_protection DUT (
		.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpuReq(cpuReq),
		.cpuVa(cpuVa), .cpuMode(cpuMode), .cpuIspace(cpuIspace), .cpuWrite(cpuWrite),
		.cpuRestart(cpuRestart), .cpuInstrDone(cpuInstrDone), .physAddr(physAddr),
		.cacheStrobe(cacheStrobe), .periphStrobe(periphStrobe), .abortReq(abortReq),
		.trapReq(trapReq), .vectorAddr(vectorAddr)
	);

	memory_side_model far (
		.sys_clk(sys_clk), .nrst(nrst), .physAddr(physAddr), .cacheStrobe(cacheStrobe),
		.periphStrobe(periphStrobe), .cacheHits(cacheHits), .periphHits(periphHits)
	);

	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;

	// ----------------------------------------------------------
	// comparisons and verdict
	// ----------------------------------------------------------
	task cmpWord(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task cmpBit(input string what, input logic exp, input logic got);
		cmpWord(what, {31'h00000000, exp}, {31'h00000000, got});
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------------------------
	// bus and processor drivers
	// ----------------------------------------------------------
	task waitRdy;
		do
			@(posedge sys_clk);
		while (hreadyout !== 1'b1);
	endtask

	// address phase held until ready, then the data phase follows
	task addrPhase(input logic [11:0] a, input logic w);
		@(posedge sys_clk);
		haddr <= {20'h00000, a};
		hwrite <= w;
		htrans <= 2'h2;
		waitRdy();
		htrans <= 2'h0;
	endtask

	task busWr(input logic [11:0] a, input logic [31:0] d);
		addrPhase(a, 1'b1);
		hwdata <= d;
		waitRdy();
	endtask

	task regChk(input string n, input logic [11:0] a, input logic [31:0] exp);
		addrPhase(a, 1'b0);
		waitRdy();
		cmpWord(n, exp, hrdata);
	endtask

	// kind: 0 cache, 1 peripheral bus, 2 abort
	task req(input logic [1:0] m, input logic isp, input logic w, input logic [15:0] v,
			input int kind, input logic [21:0] pa);
		@(posedge sys_clk);
		cpuReq <= 1'b1;
		cpuVa <= v;
		cpuMode <= m;
		cpuIspace <= isp;
		cpuWrite <= w;
		cpuRestart <= ~v;
		@(posedge sys_clk);
		cpuReq <= 1'b0;
		#1;
		cmpBit("cache", kind == 0, cacheStrobe);
		cmpBit("periph", kind == 1, periphStrobe);
		cmpBit("abort", kind == 2, abortReq);
		if (kind == 2) cmpWord("vector", 32'h000000a8, {16'h0000, vectorAddr});
		else cmpWord("phys", {10'h000, pa}, {10'h000, physAddr});
		expC += int'(kind == 0);
		expP += int'(kind == 1);
	endtask

	task instrDone(input logic expTrap);
		@(posedge sys_clk);
		cpuInstrDone <= 1'b1;
		@(posedge sys_clk);
		cpuInstrDone <= 1'b0;
		#1;
		cmpBit("trap", expTrap, trapReq);
		if (expTrap) cmpWord("tvector", 32'h000000a8, {16'h0000, vectorAddr});
	endtask

	// relocated address worked out from base and virtual address
	function automatic logic [21:0] paOf(input logic [15:0] base, input logic [15:0] v);
		logic [15:0] blk;
		blk = base + {9'h000, v[12:6]};
		return {blk, v[5:0]};
	endfunction

	function automatic logic [15:0] baseOf(input int i);
		return 16'(i * 256 + 17);
	endfunction

	function automatic logic [11:0] regAt(input logic [11:0] grp, input int i);
		return grp + 12'(4 * i);
	endfunction

	// hang guard, far beyond the well under a thousand cycles the run needs
	initial begin
		#100000;
		fails++;
		test_done();
	end

	// ----------------------------------------------------------
	// tests
	// ----------------------------------------------------------
	initial begin
		{sys_clk, nrst, hwrite, cpuReq, cpuIspace, cpuWrite, cpuInstrDone} = '0;
		{haddr, hwdata, htrans, cpuMode, cpuVa, cpuRestart, expC, expP} = '0;
		hsel = 1'b1;
		hsize = 3'h2;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		regChk("ctrl", relocation_pkg::OFS_CTRL, 32'h0);
		regChk("config", relocation_pkg::OFS_CONFIG, 32'h0);
		regChk("unmapped", 12'h300, 32'h0);
		for (int i = 0; i < 48; i++) begin
			busWr(regAt(relocation_pkg::OFS_BASE, i), {16'h0000, baseOf(i)});
			busWr(regAt(relocation_pkg::OFS_DESC, i), 32'h00007f06);
		end
		busWr(relocation_pkg::OFS_CONFIG, 32'h17);
		busWr(relocation_pkg::OFS_CTRL, 32'h1);
		// every legal mode, space and page picks its own pair
		for (int m = 0; m < 3; m++) for (int s = 0; s < 2; s++) for (int p = 0; p < 8; p++) begin
			va = {3'(p), 7'h05, 6'h15};
			req(2'(m == 2 ? 3 : m), s == 0, 1'b0, va, 0, paOf(baseOf(m * 16 + s * 8 + p), va));
		end
		// data space switched off maps data through the instruction group
		busWr(relocation_pkg::OFS_CONFIG, 32'h10);
		req(2'h0, 1'b0, 1'b0, 16'h2155, 0, paOf(baseOf(1), 16'h2155));
		busWr(relocation_pkg::OFS_CONFIG, 32'h17);
		// two pages sharing one base
		for (int p = 4; p < 8; p += 2) busWr(regAt(relocation_pkg::OFS_BASE, p), 32'h0777);
		for (int p = 4; p < 8; p += 2) begin
			va = {3'(p), 7'h28, 6'h15};
			req(2'h0, 1'b1, 1'b0, va, 0, paOf(16'h0777, va));
		end
		// top of physical space, plain memory and a carry out of the low byte
		va = {3'h7, 7'h05, 6'h02};
		for (int t = 0; t < 3; t++) begin
			busWr(regAt(relocation_pkg::OFS_BASE, 7), {16'h0000, bases[t]});
			req(2'h0, 1'b1, 1'b0, va, kinds[t], paOf(bases[t], va));
		end
		// length limit upward, then downward
		busWr(regAt(relocation_pkg::OFS_DESC, 10), 32'h0406);
		req(2'h0, 1'b0, 1'b0, 16'h4100, 0, paOf(baseOf(10), 16'h4100));
		req(2'h0, 1'b0, 1'b0, 16'h4140, 2, 22'h0);
		regChk("ctrl", relocation_pkg::OFS_CTRL, 32'h4015);
		regChk("faultva", relocation_pkg::OFS_FAULTVA, 32'h4140);
		regChk("restart", relocation_pkg::OFS_RESTART, 32'hbebf);
		busWr(relocation_pkg::OFS_CTRL, 32'h1);
		busWr(regAt(relocation_pkg::OFS_DESC, 10), 32'h040e);
		req(2'h0, 1'b0, 1'b0, 16'h40c0, 2, 22'h0);
		req(2'h0, 1'b0, 1'b0, 16'h4100, 0, paOf(baseOf(10), 16'h4100));
		req(2'h2, 1'b1, 1'b0, 16'h2155, 2, 22'h0);
		// every access key, read and write
		va = {3'h3, 7'h02, 6'h07};
		for (int k = 0; k < 8; k++) for (int w = 0; w < 2; w++) begin
			busWr(regAt(relocation_pkg::OFS_DESC, 3), 32'h7f00 | 32'(k));
			busWr(relocation_pkg::OFS_CTRL, 32'h0201);
			ab = (k == 0 || k == 3 || k == 7) || (w == 1 && (k == 1 || k == 2));
			tr = !ab && ((k == 1 && w == 0) || k == 4 || (k == 5 && w == 1));
			req(2'h0, 1'b1, 1'(w), va, ab ? 2 : 0, paOf(baseOf(3), va));
			instrDone(tr);
			if (k == 6) regChk("desc", regAt(relocation_pkg::OFS_DESC, 3), 32'h7f86 | 32'(w * 64));
		end
		// 18-bit mapping drops the high sum bits, top page folds to the bus
		busWr(regAt(relocation_pkg::OFS_BASE, 7), 32'hffc0);
		busWr(relocation_pkg::OFS_CONFIG, 32'h07);
		req(2'h0, 1'b1, 1'b0, 16'he142, 1, 22'h3ff142);
		// relocation off: straight addresses, top page to the peripheral bus
		busWr(relocation_pkg::OFS_CTRL, 32'h0);
		req(2'h0, 1'b1, 1'b0, 16'h0155, 0, 22'h000155);
		req(2'h0, 1'b1, 1'b0, 16'he155, 1, 22'h3fe155);
		@(posedge sys_clk);
		#1;
		cmpWord("cacheHits", 32'(expC), 32'(cacheHits));
		cmpWord("periphHits", 32'(expP), 32'(periphHits));
		test_done();
	end
endmodule
